/* File: pkg/sic_consts.svh */
// Register offsets, field positions, reset values and timing figures of the interlock block
`ifndef SIC_CONSTS_SVH
`define SIC_CONSTS_SVH

`define SIC_OFF_CTRL      8'h00
`define SIC_OFF_STATUS    8'h04
`define SIC_OFF_FLT_CLR   8'h08
`define SIC_OFF_BANK0     8'h10
`define SIC_NUM_BANKS     10

`define SIC_CTRL_ACT_A    1:0
`define SIC_CTRL_ACT_B    3:2
`define SIC_CTRL_HUNDRED  4
`define SIC_CTRL_BANK     8:5
`define SIC_CTRL_CHG_MS   23:16
`define SIC_CTRL_MASK     32'h00ff_01ff

`define SIC_BANK_START    1:0
`define SIC_BANK_RESP_MS  9:2
`define SIC_BANK_MAX_SPD  25:10

`define SIC_CTRL_RESET    32'h0000_0000
`define SIC_BANK_RESET    26'h00000a2

`define SIC_CLK_PERIOD_NS 5
`define SIC_MS_NS         1000000
`define SIC_PRESS_MIN_S   0.12
`define SIC_PRESS_MAX_S   4.0
`define SIC_SYNC_MS       40

`endif

/* File: pkg/sic_pkg.sv */
// Types and selection decoding shared by the interlock block
package sic_pkg;
  typedef enum logic [1:0] {START_AUTO = 2'h0, START_LOCK = 2'h1, START_FULL = 2'h2} sic_start_t;
  typedef enum logic [1:0] {ACT_FIXED = 2'h0, ACT_OVERLAP = 2'h1, ACT_MOMENT = 2'h2} sic_act_t;
  typedef enum logic [1:0] {CHG_STABLE = 2'h0, CHG_RUN = 2'h1, CHG_FAULT = 2'h3} sic_chg_state_t;

  // five select lines to pair 1..10, zero when not a legal pattern
  function automatic logic [3:0] decode_pair(input logic [4:0] s);
    case (s)
      5'h01:   decode_pair = 4'h1;
      5'h02:   decode_pair = 4'h2;
      5'h04:   decode_pair = 4'h3;
      5'h08:   decode_pair = 4'h4;
      5'h10:   decode_pair = 4'h5;
      5'h0f:   decode_pair = 4'h6;
      5'h17:   decode_pair = 4'h7;
      5'h1b:   decode_pair = 4'h8;
      5'h1d:   decode_pair = 4'h9;
      5'h1e:   decode_pair = 4'ha;
      default: decode_pair = 4'h0;
    endcase
  endfunction

  function automatic logic [4:0] pair_mask(input logic [3:0] p);
    case (p)
      4'h1:    pair_mask = 5'h01;
      4'h2:    pair_mask = 5'h02;
      4'h3:    pair_mask = 5'h04;
      4'h4:    pair_mask = 5'h08;
      4'h5:    pair_mask = 5'h10;
      4'h6:    pair_mask = 5'h0f;
      4'h7:    pair_mask = 5'h17;
      4'h8:    pair_mask = 5'h1b;
      4'h9:    pair_mask = 5'h1d;
      4'ha:    pair_mask = 5'h1e;
      default: pair_mask = 5'h00;
    endcase
  endfunction
endpackage

/* File: pkg/sic_chg_if.sv */
// Settings and results between the top and one changeover tracker
interface sic_chg_if;
  logic [1:0] mode;
  logic [7:0] chg_ms;
  logic [4:0] sel;
  logic       tick;
  logic       clr;
  logic [3:0] pair;
  logic       fault;
  logic       busy;
  logic       switched;
  modport dev (input mode, chg_ms, sel, tick, clr, output pair, fault, busy, switched);
  modport ctl (output mode, chg_ms, sel, tick, clr, input pair, fault, busy, switched);
endinterface

/* File: hdl/sic_chg.sv */
// Field pair changeover tracker for one protective function
module sic_chg (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  sic_chg_if.dev   cif  // settings in, monitored pair out
);
  sic_pkg::sic_chg_state_t state, next_state;
  logic [3:0] pair, next_pair;
  logic [3:0] cand, next_cand;
  logic [7:0] tmr, next_tmr;
  logic [4:0] sel_last, next_sel_last;
  logic       switched, next_switched;
  logic [3:0] dec;
  logic [3:0] dec_other;
  logic [4:0] cur_mask;
  logic [4:0] cand_mask;
  logic [2:0] ones;
  logic       expire;

  always_comb begin
    dec           = sic_pkg::decode_pair(cif.sel);
    cur_mask      = sic_pkg::pair_mask(pair);
    cand_mask     = sic_pkg::pair_mask(cand);
    dec_other     = sic_pkg::decode_pair(cif.sel & ~cur_mask);
    ones          = 3'($countones(cif.sel));
    expire        = cif.tick && tmr == 8'h00;
    next_state    = state;
    next_pair     = pair;
    next_cand     = cand;
    next_tmr      = tmr;
    next_sel_last = sel_last;
    next_switched = 1'b0;
    if (cif.mode == sic_pkg::ACT_FIXED) begin
      // inputs ignored, first pair always watched
      next_state = sic_pkg::CHG_STABLE;
      next_pair  = 4'h1;
    end else begin
      case (state)
        sic_pkg::CHG_STABLE: begin
          if (cif.mode == sic_pkg::ACT_OVERLAP) begin
            if (cif.sel != cur_mask) begin
              // new pair must join before the old one leaves
              if (ones == 3'h2 && (cif.sel & cur_mask) != 5'h00 && dec_other != 4'h0) begin
                next_state = sic_pkg::CHG_RUN;
                next_cand  = dec_other;
                next_tmr   = cif.chg_ms;
              end else begin
                next_state = sic_pkg::CHG_FAULT;
              end
            end
          end else if (cif.sel != sel_last) begin
            next_state = sic_pkg::CHG_RUN;
            next_tmr   = cif.chg_ms;
          end
        end
        sic_pkg::CHG_RUN: begin
          if (cif.mode == sic_pkg::ACT_OVERLAP) begin
            if (cif.sel == cur_mask) begin
              next_state = sic_pkg::CHG_STABLE;
            end else if (cif.sel == cand_mask) begin
              next_pair     = cand;
              next_switched = 1'b1;
              next_state    = sic_pkg::CHG_STABLE;
            end else if (cif.sel != (cur_mask | cand_mask) || expire) begin
              next_state = sic_pkg::CHG_FAULT;
            end else if (cif.tick) begin
              next_tmr = tmr - 8'h01;
            end
          end else if (expire) begin
            // old pair stays watched until the changeover time runs out
            if (dec != 4'h0) begin
              next_pair     = dec;
              next_switched = dec != pair;
              next_sel_last = cif.sel;
              next_state    = sic_pkg::CHG_STABLE;
            end else begin
              next_state = sic_pkg::CHG_FAULT;
            end
          end else if (cif.tick) begin
            next_tmr = tmr - 8'h01;
          end
        end
        sic_pkg::CHG_FAULT: begin
          if (cif.clr) begin
            next_state    = sic_pkg::CHG_STABLE;
            next_pair     = (dec != 4'h0) ? dec : 4'h1;
            next_sel_last = cif.sel;
          end
        end
        default: next_state = sic_pkg::CHG_FAULT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= sic_pkg::CHG_STABLE;
      pair     <= 4'h1;
      cand     <= 4'h1;
      tmr      <= 8'h00;
      sel_last <= 5'h01;
      switched <= 1'b0;
    end else begin
      state    <= next_state;
      pair     <= next_pair;
      cand     <= next_cand;
      tmr      <= next_tmr;
      sel_last <= next_sel_last;
      switched <= next_switched;
    end
  end

  assign cif.pair     = pair;
  assign cif.fault    = state == sic_pkg::CHG_FAULT;
  assign cif.busy     = state == sic_pkg::CHG_RUN;
  assign cif.switched = switched;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fixed_pair: assert property (cif.mode == sic_pkg::ACT_FIXED |=> pair == 4'h1 && !cif.fault)
    else $error("fixed mode left the first pair");
  a_old_pair_kept: assert property ((state == sic_pkg::CHG_RUN && cif.mode == sic_pkg::ACT_MOMENT && !expire)
    |=> pair == $past(pair))
    else $error("pair changed before changeover time ran out");
  a_expiry_invalid: assert property ((state == sic_pkg::CHG_RUN && cif.mode == sic_pkg::ACT_MOMENT && expire
    && dec == 4'h0) |=> cif.fault)
    else $error("invalid selection at expiry not flagged");
  a_overlap_many: assert property ((state == sic_pkg::CHG_STABLE && cif.mode == sic_pkg::ACT_OVERLAP
    && ones > 3'h2) |=> cif.fault)
    else $error("more than two selected pairs not flagged");
endmodule // sic_chg

/* File: hdl/sic_top.sv */
// Output release, start interlock and field pair changeover with AHB-Lite registers
//
// Functional notes
// - auto mode releases outputs without operator once supply is up and field free.
// - start interlock mode keeps outputs off after power-up until a valid press.
// - start interlock mode re-enables outputs by itself once the field clears.
// - full interlock keeps outputs off after violation or power-up until valid press.
// - a press counts only when held between 0.12 s and 4 s.
// - outputs drop within the bank response time after a field violation.
// - start-up behaviour is one setting per bank, shared by all its pairs.
// - vehicle speed is checked against the per-bank maximum vehicle speed.
// - ten banks of ten pairs, or one hundred pairs, switchable at any time.
// - function A and function B each have their own changeover tracker, but hundred-pair mode holds B in fixed mode.
// - active pair is chosen from the select inputs driven by the controller.
// - modes are fixed pair, overlapped monitoring, and fixed changeover moment.
// - a broken changeover raises a fault, drops outputs, and shows a diagnostic.
// - the previous pair stays monitored while a changeover runs.
// - changeover onto an occupied field drops outputs after response time plus 40 ms.
// - fixed mode always watches the first pair of the bank in use, ignoring inputs.
// - inputs one to five pick function A pairs, six to ten function B, or the bank in hundred-pair mode.
// - fixed moment timer starts on any input change; expiry needs one valid pattern.
`include "sic_consts.svh"
module sic_top #(
  parameter int TICK_CYCLES = `SIC_MS_NS / `SIC_CLK_PERIOD_NS // core cycles per millisecond tick
) (
  input  wire logic        CLK,                    // core clock, 200 MHz
  input  wire logic        RST,                    // synchronous reset, active high
  input  wire logic        HSEL,                   // slave select
  input  wire logic [31:0] HADDR,                  // byte address
  input  wire logic [1:0]  HTRANS,                 // transfer type
  input  wire logic        HWRITE,                 // write when high
  input  wire logic [2:0]  HSIZE,                  // transfer size, word only
  input  wire logic [31:0] HWDATA,                 // write data
  input  wire logic        HREADY,                 // bus ready
  output logic      [31:0] HRDATA,                 // read data
  output logic             HREADYOUT,              // slave ready
  output logic             HRESP,                  // always OKAY
  input  wire logic [9:0]  SELECT_INPUT,           // select_input_first .. select_input_tenth
  input  wire logic        RESET_BUTTON,           // operator button, high while pressed
  input  wire logic        FIELD_OCC_A,            // function A protective field violated
  input  wire logic        FIELD_OCC_B,            // function B protective field violated
  input  wire logic [15:0] DRIVERLESS_VEHICLE_SPEED, // current vehicle speed
  output logic             SAFETY_SWITCH_OUTPUT_A, // function A release
  output logic             SAFETY_SWITCH_OUTPUT_B, // function B release
  output logic             FAULT                   // changeover fault
);
  // tick sampling makes the press window a little narrower, never wider
  localparam int PMIN_T = int'($ceil(`SIC_PRESS_MIN_S * 1000.0)) + 1;
  localparam int PMAX_T = int'($floor(`SIC_PRESS_MAX_S * 1000.0)) - 1;
  localparam int SYNC_T = `SIC_SYNC_MS;
  localparam int TW     = $clog2(TICK_CYCLES + 1);

  function automatic logic bank_hit(input logic [7:0] a);
    bank_hit = a >= `SIC_OFF_BANK0 && a < `SIC_OFF_BANK0 + 8'(4 * `SIC_NUM_BANKS) && a[1:0] == 2'h0;
  endfunction

  function automatic logic [3:0] bank_idx(input logic [7:0] a);
    logic [7:0] d;
    d        = a - `SIC_OFF_BANK0;
    bank_idx = d[5:2];
  endfunction

  logic [28:0] pin_s1, pin_s2;
  logic [9:0]  sel;
  logic        btn;
  logic [1:0]  occ;
  logic [15:0] speed;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {DRIVERLESS_VEHICLE_SPEED, FIELD_OCC_B, FIELD_OCC_A, RESET_BUTTON, SELECT_INPUT};
      pin_s2 <= pin_s1;
    end
  end
  assign sel   = pin_s2[9:0];
  assign btn   = pin_s2[10];
  assign occ   = pin_s2[12:11];
  assign speed = pin_s2[28:13];

  // millisecond tick
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic          tick, next_tick;
  always_comb begin
    next_tick     = tick_cnt == TW'(TICK_CYCLES - 1);
    next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // register file over AHB-Lite, zero wait states
  logic [31:0] ctrl, next_ctrl;
  logic [25:0] bank_cfg [`SIC_NUM_BANKS];
  logic [25:0] next_bank_cfg [`SIC_NUM_BANKS];
  logic [1:0]  clr, next_clr;
  logic        a_wr, next_a_wr;
  logic [7:0]  a_addr, next_a_addr;
  logic [31:0] next_rdata;
  logic [31:0] status;
  logic        take;
  always_comb begin
    take          = HSEL && HTRANS[1] && HREADY;
    next_ctrl     = ctrl;
    next_bank_cfg = bank_cfg;
    next_clr      = 2'h0;
    next_a_wr     = take && HWRITE;
    next_a_addr   = HADDR[7:0];
    next_rdata    = HRDATA;
    if (a_wr) begin
      if (a_addr == `SIC_OFF_CTRL) begin
        next_ctrl = HWDATA & `SIC_CTRL_MASK;
      end else if (a_addr == `SIC_OFF_FLT_CLR) begin
        next_clr = HWDATA[1:0];
      end else if (bank_hit(a_addr)) begin
        next_bank_cfg[bank_idx(a_addr)] = HWDATA[25:0];
      end
    end
    // read data caught at the address phase so it comes from a flop
    if (take && !HWRITE) begin
      if (HADDR[7:0] == `SIC_OFF_CTRL) begin
        next_rdata = ctrl;
      end else if (HADDR[7:0] == `SIC_OFF_STATUS) begin
        next_rdata = status;
      end else if (bank_hit(HADDR[7:0])) begin
        next_rdata = {6'h00, bank_cfg[bank_idx(HADDR[7:0])]};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl      <= `SIC_CTRL_RESET;
      bank_cfg  <= '{default: `SIC_BANK_RESET};
      clr       <= 2'h0;
      a_wr      <= 1'b0;
      a_addr    <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      bank_cfg  <= next_bank_cfg;
      clr       <= next_clr;
      a_wr      <= next_a_wr;
      a_addr    <= next_a_addr;
      HRDATA    <= next_rdata;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // changeover trackers, one per protective function
  logic hundred;
  assign hundred = ctrl[`SIC_CTRL_HUNDRED];
  sic_chg_if cif_a ();
  sic_chg_if cif_b ();
  assign cif_a.mode   = ctrl[`SIC_CTRL_ACT_A];
  assign cif_a.chg_ms = ctrl[`SIC_CTRL_CHG_MS];
  assign cif_a.sel    = sel[4:0];
  assign cif_a.tick   = tick;
  assign cif_a.clr    = clr[0];
  // in hundred-pair mode the upper inputs pick the bank, so B stays parked
  assign cif_b.mode   = hundred ? sic_pkg::ACT_FIXED : ctrl[`SIC_CTRL_ACT_B];
  assign cif_b.chg_ms = ctrl[`SIC_CTRL_CHG_MS];
  assign cif_b.sel    = sel[9:5];
  assign cif_b.tick   = tick;
  assign cif_b.clr    = clr[1];
  sic_chg u_chg_a (.clk(CLK), .rst(RST), .cif(cif_a));
  sic_chg u_chg_b (.clk(CLK), .rst(RST), .cif(cif_b));

  // bank in use and its settings
  logic [3:0]  bank, next_bank;
  logic [3:0]  row;
  logic [25:0] cur;
  logic [1:0]  start_mode;
  logic [1:0]  flt;
  logic [1:0]  sw;
  always_comb begin
    row = sic_pkg::decode_pair(sel[9:5]);
    if (hundred) begin
      next_bank = (row != 4'h0) ? row - 4'h1 : bank;
    end else begin
      next_bank = (ctrl[`SIC_CTRL_BANK] > 4'h9) ? 4'h9 : ctrl[`SIC_CTRL_BANK];
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      bank <= 4'h0;
    end else begin
      bank <= next_bank;
    end
  end
  assign cur        = bank_cfg[bank];
  assign start_mode = cur[`SIC_BANK_START];
  assign flt        = {cif_b.fault && !hundred, cif_a.fault};
  assign sw         = {cif_b.switched, cif_a.switched};

  // reset press timing and output release
  logic [11:0] press_cnt, next_press_cnt;
  logic        btn_q, press_ok, next_press_ok;
  logic [1:0]  out, next_out;
  logic [1:0]  start_restart_lock, next_start_restart_lock;
  logic [8:0]  vcnt [2];
  logic [8:0]  next_vcnt [2];
  logic [8:0]  lim [2];
  logic [1:0]  post, next_post;
  logic        ovs, next_ovs;
  logic        next_fault;
  always_comb begin
    next_press_cnt = !btn ? 12'h000 : (tick && press_cnt != 12'hfff) ? press_cnt + 12'h001 : press_cnt;
    next_press_ok  = btn_q && !btn && press_cnt >= 12'(PMIN_T) && press_cnt <= 12'(PMAX_T);
    next_ovs       = speed > cur[`SIC_BANK_MAX_SPD];
    next_fault     = |flt;
    for (int f = 0; f < 2; f++) begin
      lim[f]       = {1'b0, cur[`SIC_BANK_RESP_MS]} + (post[f] ? 9'(SYNC_T) : 9'h000);
      next_vcnt[f] = !occ[f] ? 9'h000 : (tick && vcnt[f] != 9'h1ff) ? vcnt[f] + 9'h001 : vcnt[f];
      next_post[f] = occ[f] && (sw[f] || post[f]);
      // release only on a free field; hold through occupation until the limit
      next_out[f]  = !flt[f] && !start_restart_lock[f] && !(f == 1 && hundred)
                     && (occ[f] ? (out[f] && vcnt[f] < lim[f]) : 1'b1);
      next_start_restart_lock[f] = start_restart_lock[f];
      if (start_mode == sic_pkg::START_AUTO) begin
        next_start_restart_lock[f] = 1'b0;
      end else if (flt[f]) begin
        next_start_restart_lock[f] = 1'b1;
      end else if (start_mode == sic_pkg::START_FULL && out[f] && occ[f] && vcnt[f] >= lim[f]) begin
        next_start_restart_lock[f] = 1'b1;
      end else if (press_ok && !occ[f]) begin
        next_start_restart_lock[f] = 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      press_cnt          <= 12'h000;
      btn_q              <= 1'b0;
      press_ok           <= 1'b0;
      out                <= 2'h0;
      start_restart_lock <= 2'h3;
      vcnt               <= '{default: 9'h000};
      post               <= 2'h0;
      ovs                <= 1'b0;
      FAULT              <= 1'b0;
    end else begin
      press_cnt          <= next_press_cnt;
      btn_q              <= btn;
      press_ok           <= next_press_ok;
      out                <= next_out;
      start_restart_lock <= next_start_restart_lock;
      vcnt               <= next_vcnt;
      post               <= next_post;
      ovs                <= next_ovs;
      FAULT              <= next_fault;
    end
  end
  assign SAFETY_SWITCH_OUTPUT_A = out[0];
  assign SAFETY_SWITCH_OUTPUT_B = out[1];

  assign status = {10'h000, cif_b.busy, cif_a.busy, bank, cif_b.pair, cif_a.pair, 1'b0, ovs, flt,
                   start_restart_lock, out};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_auto_start: assert property ((start_mode == sic_pkg::START_AUTO && !flt[0] && !occ[0]) [*3]
    |=> SAFETY_SWITCH_OUTPUT_A)
    else $error("auto mode did not release on a free field");
  a_start_locked: assert property ((start_restart_lock[0] && !press_ok && start_mode != sic_pkg::START_AUTO) [*2]
    |=> !SAFETY_SWITCH_OUTPUT_A)
    else $error("output released while interlocked");
  a_auto_restart: assert property ((start_mode == sic_pkg::START_LOCK && !start_restart_lock[0] && !flt[0]
    && !occ[0]) [*2] |=> SAFETY_SWITCH_OUTPUT_A)
    else $error("no automatic restart after field cleared");
  a_full_relock: assert property ((start_mode == sic_pkg::START_FULL && !flt[0] && $fell(SAFETY_SWITCH_OUTPUT_A))
    |-> start_restart_lock[0])
    else $error("full interlock not engaged after trip");
  a_press_window: assert property (press_ok |-> $past(press_cnt) >= 12'(PMIN_T)
    && $past(press_cnt) <= 12'(PMAX_T))
    else $error("press accepted outside its window");
  a_press_reject: assert property ((btn_q && !btn && press_cnt > 12'(PMAX_T) && start_restart_lock[0]
    && start_mode != sic_pkg::START_AUTO && !btn) |=> ##1 start_restart_lock[0])
    else $error("overlong press unlocked the output");
  a_resp_off: assert property ((occ[0] && vcnt[0] > lim[0]) |-> !SAFETY_SWITCH_OUTPUT_A)
    else $error("output still on after response time");
  a_sync_hold: assert property ((SAFETY_SWITCH_OUTPUT_A && occ[0] && post[0] && !flt[0] && !start_restart_lock[0]
    && vcnt[0] < lim[0]) |=> SAFETY_SWITCH_OUTPUT_A)
    else $error("output dropped before synchronisation delay");
  a_fault_off: assert property ($rose(flt[0]) |=> FAULT && !SAFETY_SWITCH_OUTPUT_A)
    else $error("changeover fault did not drop output");
  a_hundred_b: assert property (hundred |=> !SAFETY_SWITCH_OUTPUT_B)
    else $error("function B active in hundred-pair mode");

  c_press_release: cover property (press_ok ##[1:4] SAFETY_SWITCH_OUTPUT_A);
  c_occupied_change: cover property (cif_a.switched && occ[0]);
  c_fault_seen: cover property ($rose(FAULT));
endmodule // sic_top

/* File: sim/sic_partner.sv */
// Machine controller and operator button model facing the interlock block
module sic_partner #(
  parameter int TICK = 20 // core cycles per ms tick
) (
  input  wire logic        clk,   // core clock
  output logic      [9:0]  sel,   // select lines
  output logic             btn,   // reset button, high = pressed
  output logic             occ_a, // field A violated
  output logic             occ_b, // field B violated
  output logic      [15:0] speed  // vehicle speed, zero until the bench sets it
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel = 10'h021;
    btn = 1'b0;
    occ_a = 1'b0;
    occ_b = 1'b0;
    speed = 16'h0000;
  end
  // operator holds the button for the whole count
  task automatic press(input int n_ms);
    btn <= 1'b1;
    repeat (n_ms * TICK) @(posedge clk);
    btn <= 1'b0;
  endtask
  // controller drives only the patterns it is told to
  task automatic select(input logic [9:0] s);
    sel <= s;
  endtask
endmodule // sic_partner

/* File: sim/tb_top.sv */
// Self-checking bench for the interlock block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hrdy, hresp, fault, oa, ob;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [9:0]  sel;
  logic [15:0] spd;
  logic        btn, occ_a, occ_b;
  logic [4:0]  masks [10] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0f, 5'h17, 5'h1b, 5'h1d, 5'h1e};
  int          bad_count, n_tests, seed, i, k;
  sic_partner #(.TICK(20)) sic_partner_i (.clk(clk), .sel(sel), .btn(btn), .occ_a(occ_a), .occ_b(occ_b), .speed(spd));
  sic_top #(.TICK_CYCLES(20)) sic_top_i (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .SELECT_INPUT(sel), .RESET_BUTTON(btn), .FIELD_OCC_A(occ_a), .FIELD_OCC_B(occ_b),
    .DRIVERLESS_VEHICLE_SPEED(spd), .SAFETY_SWITCH_OUTPUT_A(oa), .SAFETY_SWITCH_OUTPUT_B(ob), .FAULT(fault));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait for hready; a stuck slave ends the run
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hrdy !== 1'b1 && k < 100);
    if (k >= 100) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  // expected pair number for a table index, pairs count from one
  function automatic logic [3:0] pair_of(input int n);
    pair_of = 4'(n + 1);
  endfunction
  task automatic ms(input int n);
    repeat (n * 20 + 10) @(posedge clk);
  endtask
  initial begin
    seed = 37533;
    {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 32'h10, 32'h0);
    check("bank0 reset", q, 32'h0000_00a2);
    bus(1'b0, 32'h40, 32'h0);
    check("unmapped read", q, 32'h0);
    check("hresp okay", hresp, 1'b0);
    check("out after reset", {oa, ob}, 2'b00);
    bus(1'b1, 32'h10, 32'h16);
    sic_partner_i.press(50);
    ms(1);
    check("short press", oa, 1'b0);
    sic_partner_i.press(200);
    ms(1);
    check("valid press", {oa, ob}, 2'b11);
    $display("test interlock done");
    sic_partner_i.occ_a <= 1'b1;
    ms(3);
    check("before resp", oa, 1'b1);
    ms(3);
    check("resp drop", oa, 1'b0);
    sic_partner_i.occ_a <= 1'b0;
    ms(2);
    check("restart lock", oa, 1'b0);
    bus(1'b1, 32'h10, 32'h14);
    ms(2);
    check("auto start", {oa, ob}, 2'b11);
    bus(1'b1, 32'h10, 32'h15);
    sic_partner_i.occ_a <= 1'b1;
    ms(6);
    sic_partner_i.occ_a <= 1'b0;
    ms(2);
    check("auto restart", oa, 1'b1);
    $display("test start modes done");
    bus(1'b1, 32'h00, 32'h0005_000a);
    for (i = 0; i < 6; i++) begin
      k = ($random(seed) & 32'h7fff_ffff) % 10;
      sic_partner_i.select({5'h01, masks[k]});
      ms(8);
      bus(1'b0, 32'h04, 32'h0);
      check("pair A", {28'h0, q[11:8]}, 32'(pair_of(k)));
      check("pair B", {28'h0, q[15:12]}, 32'h1);
    end
    sic_partner_i.select({5'h01, 5'h03});
    ms(8);
    check("fault at expiry", {fault, oa}, 2'b10);
    sic_partner_i.select({5'h01, 5'h02});
    ms(1);
    bus(1'b1, 32'h08, 32'h1);
    ms(1);
    bus(1'b0, 32'h04, 32'h0);
    check("fault clear", {27'h0, fault, q[11:8]}, 32'h2);
    sic_partner_i.press(200);
    ms(1);
    check("press after fault", oa, 1'b1);
    bus(1'b1, 32'h00, 32'h0005_0009);
    sic_partner_i.select({5'h01, 5'h06});
    ms(2);
    bus(1'b0, 32'h04, 32'h0);
    check("overlap busy", {27'h0, q[20], q[11:8]}, 32'h12);
    sic_partner_i.select({5'h01, 5'h04});
    ms(1);
    bus(1'b0, 32'h04, 32'h0);
    check("overlap done", {27'h0, q[20], q[11:8]}, 32'h3);
    sic_partner_i.select({5'h01, 5'h07});
    ms(1);
    check("overlap three", fault, 1'b1);
    sic_partner_i.select({5'h01, 5'h04});
    ms(1);
    bus(1'b1, 32'h08, 32'h1);
    ms(1);
    check("overlap clear", fault, 1'b0);
    $display("test changeover done");
    sic_partner_i.speed <= 16'h0010;
    ms(1);
    bus(1'b0, 32'h04, 32'h0);
    check("overspeed", q[6], 1'b1);
    bus(1'b1, 32'h00, 32'h0000_0010);
    sic_partner_i.select({5'h02, 5'h01});
    ms(1);
    bus(1'b0, 32'h04, 32'h0);
    check("hundred bank", {23'h0, ob, q[19:16], q[11:8]}, 32'h0000_0011);
    $display("test modes done");
    tally_and_finish();
  end
endmodule // tb_top
